// [shared/rsx_consts.vh]
// Constants for the return stack and call/reset execution block.
// Assumes a 21-bit byte program counter and 16-bit instruction words.
`ifndef RSX_CONSTS_VH
`define RSX_CONSTS_VH
`define RSX_PC_W 21
`define RSX_PTR_W 5
`define RSX_DEPTH 31
`define RSX_PC_RESET 21'h00_0000
`define RSX_PTR_RESET 5'h00
`define RSX_STAT_RESET 5'h00
`define RSX_OP_DISCARD 16'h0006
`define RSX_OP_PUSH 16'h0005
`define RSX_OP_SWRESET 16'h00FF
`define RSX_RELATIVE_SUBROUTINE_CALL_MASK 16'hF800
`define RSX_RELATIVE_SUBROUTINE_CALL_CODE 16'hD800
`define RSX_OFS_MSB 10
`define RSX_PC_STEP 21'h00_0002
`define RSX_Q_LAST 2'h3
`define RSX_Q_FIRST 2'h0
`endif

// [rtl/rsx_stack.v]
// Return stack storage: an indexed array addressed by a pointer.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/10ps
`include "rsx_consts.vh"
module rsx_stack (
  input wire mclk,
  input wire rst_n,
  input wire push,
  input wire pop,
  input wire [`RSX_PC_W-1:0] push_value,
  output wire [`RSX_PC_W-1:0] stack_top_value,
  output wire [`RSX_PTR_W-1:0] stack_ptr
);
  reg [`RSX_PC_W-1:0] mem [0:`RSX_DEPTH];
  reg [`RSX_PTR_W-1:0] ptr_reg;
  reg [`RSX_PTR_W-1:0] ptr_next;
  // =========================================================
  // Pointer
  // =========================================================
  always @*
  begin
    ptr_next = ptr_reg;
    if (push)
    begin
      ptr_next = ptr_reg + 1'b1;
    end
    else if (pop)
    begin
      ptr_next = ptr_reg - 1'b1;
    end
  end
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg <= `RSX_PTR_RESET;
    end
    else
    begin
      ptr_reg <= ptr_next;
    end
  end
  // The array itself is not reset; entries 1 up to the pointer are written
  // before they can be read, but entry 0 is read unwritten after reset.
  always @(posedge mclk)
  begin
    if (push)
    begin
      mem[ptr_next] <= push_value;
    end
  end
  assign stack_top_value = mem[ptr_reg];
  assign stack_ptr = ptr_reg;
endmodule

// [rtl/rsx_exec.v]
// Execution of discard, push, relative call and software reset.
// Assumes one instruction word per cycle, sampled at phase 0, with
// a four-phase counter kept here that the software reset restarts.
`timescale 1ns/10ps
`include "rsx_consts.vh"
module rsx_exec (
  input wire mclk,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [4:0] status_in,
  output reg [`RSX_PC_W-1:0] pc_out,
  output reg [4:0] status_out,
  output wire [`RSX_PC_W-1:0] stack_top_value,
  output wire [`RSX_PTR_W-1:0] stack_ptr,
  output reg master_clear_reset,
  output wire busy,
  output wire [1:0] q_phase
);
  // A relative call spends the rest of its own instruction cycle in
  // ST_FLUSH and the whole next one in ST_IDLE while the fetch refills.
  localparam ST_RUN = 2'b00;
  localparam ST_FLUSH = 2'b01;
  localparam ST_IDLE = 2'b10;
  // Instruction classes handled by this block.
  localparam CL_NONE = 3'b000;
  localparam CL_DISCARD = 3'b001;
  localparam CL_PUSH = 3'b010;
  localparam CL_CALL = 3'b011;
  localparam CL_RESET = 3'b100;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] q_reg;
  reg [`RSX_PC_W-1:0] pc_next;
  reg [4:0] status_next;
  reg reset_next;
  reg push_req;
  reg pop_req;
  wire [`RSX_PC_W-1:0] pc_inc;
  wire [`RSX_PC_W-1:0] offset_x2;
  wire take;
  wire [2:0] op_class;
  wire stack_rst_n;
  // Sorts an instruction word into one of the classes above.
  function [2:0] rsx_op_class;
    input [15:0] w;
    begin
      if (w == `RSX_OP_DISCARD)
      begin
        rsx_op_class = CL_DISCARD;
      end
      else if (w == `RSX_OP_PUSH)
      begin
        rsx_op_class = CL_PUSH;
      end
      else if ((w & `RSX_RELATIVE_SUBROUTINE_CALL_MASK) == `RSX_RELATIVE_SUBROUTINE_CALL_CODE)
      begin
        rsx_op_class = CL_CALL;
      end
      else if (w == `RSX_OP_SWRESET)
      begin
        rsx_op_class = CL_RESET;
      end
      else
      begin
        rsx_op_class = CL_NONE;
      end
    end
  endfunction
  // The program counter holds the byte address of the word in hand;
  // every instruction word is two bytes long.
  assign pc_inc = pc_out + `RSX_PC_STEP;
  // Offset is sign extended to the PC width and scaled to bytes.
  assign offset_x2 = {{(`RSX_PC_W-`RSX_OFS_MSB-2)
                       {instr_word[`RSX_OFS_MSB]}},
                      instr_word[`RSX_OFS_MSB:0], 1'b0};
  assign take = instr_valid && (q_reg == `RSX_Q_FIRST) &&
                (state_reg == ST_RUN) && !master_clear_reset;
  assign busy = (state_reg != ST_RUN);
  assign q_phase = q_reg;
  assign op_class = rsx_op_class(instr_word);
  // The stack pointer is cleared by the pin reset and by the software
  // reset pulse alike; the pulse comes from a flop, so it is clean.
  assign stack_rst_n = rst_n & ~master_clear_reset;
  // =========================================================
  // Decode and next state
  // =========================================================
  // Only a word taken at phase 0 of a free instruction cycle is
  // decoded; a word offered in another phase or while the fetch
  // refills is dropped without notice.
  always @*
  begin
    state_next = state_reg;
    pc_next = pc_out;
    status_next = status_in;
    reset_next = 1'b0;
    push_req = 1'b0;
    pop_req = 1'b0;
    if (master_clear_reset)
    begin
      // The pulse wins over any word offered in the same cycle.
      // all back to reset
      pc_next = `RSX_PC_RESET;
      status_next = `RSX_STAT_RESET;
      state_next = ST_RUN;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (take)
          begin
            pc_next = pc_inc;
            case (op_class)
              CL_DISCARD:
              begin
                pop_req = 1'b1;
              end
              CL_PUSH:
              begin
                push_req = 1'b1;
              end
              CL_CALL:
              begin
                push_req = 1'b1;
                pc_next = pc_inc + offset_x2;
                state_next = ST_FLUSH;
              end
              CL_RESET:
              begin
                reset_next = 1'b1;
              end
              default:
              begin
                // Unknown words only advance the program counter.
                pc_next = pc_inc;
              end
            endcase
          end
        end
        ST_FLUSH:
        begin
          if (q_reg == `RSX_Q_LAST)
          begin
            state_next = ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (q_reg == `RSX_Q_LAST)
          begin
            state_next = ST_RUN;
          end
        end
        default:
        begin
          // An unused code falls back to normal running.
          state_next = ST_RUN;
        end
      endcase
    end
  end
  // =========================================================
  // Registers
  // =========================================================
  // The reset pulse lasts one cycle and is also exported so the rest
  // of the core can clear its own state the same way as the pin does.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
      q_reg <= `RSX_Q_FIRST;
      pc_out <= `RSX_PC_RESET;
      status_out <= `RSX_STAT_RESET;
      master_clear_reset <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // Restarting the phase count after a software reset lines the
      // next word up with the start of a fresh instruction cycle.
      q_reg <= master_clear_reset ? `RSX_Q_FIRST : q_reg + 1'b1;
      pc_out <= pc_next;
      status_out <= status_next;
      master_clear_reset <= reset_next;
    end
  end
  // =========================================================
  // Return stack
  // =========================================================
  // Return addresses pushed here are byte addresses of the word after
  // the one being executed, so a later return resumes past it.
  rsx_stack i_rsx_stack (
    .mclk(mclk),
    .rst_n(stack_rst_n),
    .push(push_req),
    .pop(pop_req),
    .push_value(pc_inc),
    .stack_top_value(stack_top_value),
    .stack_ptr(stack_ptr)
  );
endmodule

// [dv/rsx_exec_monitor.sv]
// Port checker for rsx_exec, bound into every instance.
// Assumes rsx_consts.vh is on the include path.
`timescale 1ns/10ps
`include "rsx_consts.vh"
module rsx_exec_monitor (
  input wire mclk,
  input wire rst_n,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [4:0] status_in,
  input wire [20:0] pc_out,
  input wire [4:0] status_out,
  input wire [20:0] stack_top_value,
  input wire [4:0] stack_ptr,
  input wire master_clear_reset,
  input wire busy,
  input wire [1:0] q_phase
);
  // ====
  // Decode of a taken word
  wire tk = instr_valid && !q_phase && !busy && !master_clear_reset;
  wire [15:0] w = instr_word;
  wire pu = tk && w == `RSX_OP_PUSH;
  wire po = tk && w == `RSX_OP_DISCARD;
  wire ca = tk && (w & `RSX_RELATIVE_SUBROUTINE_CALL_MASK) == `RSX_RELATIVE_SUBROUTINE_CALL_CODE;
  wire [20:0] nx = pc_out + 21'h2;
  wire [20:0] tg = nx + {{9{w[10]}}, w[10:0], 1'h0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_flush;
    busy [*7] ##1 !busy;
  endsequence
  sequence s_clear;
    master_clear_reset ##1 !master_clear_reset && !pc_out && !stack_ptr
      && !status_out;
  endsequence
  // ====
  // Assertions
  a_pop_lowers: assert property (
    po |=> stack_ptr == $past(stack_ptr) - 5'h1) else $error("pop ptr");
  a_push_raises: assert property (
    pu |=> stack_ptr == $past(stack_ptr) + 5'h1) else $error("push ptr");
  a_return_top: assert property (
    pu || ca |=> stack_top_value == $past(nx)) else $error("push top");
  a_call_target: assert property (
    ca |=> pc_out == $past(tg)) else $error("call target");
  a_call_flush: assert property (
    ca |=> s_flush) else $error("call flush");
  a_flush_hold: assert property (
    busy |=> $stable(pc_out)) else $error("pc moved");
  a_soft_clear: assert property (
    tk && w == `RSX_OP_SWRESET |=> s_clear) else $error("soft reset");
  a_flags_kept: assert property (
    pu || po |=> status_out == $past(status_in)) else $error("flags");
endmodule
bind rsx_exec rsx_exec_monitor i_rsx_exec_monitor (.*);

// [dv/return_stack_call_reset_ops_test.sv]
// Bench for rsx_exec: push, discard, relative call, soft reset.
// Assumes the port checker is bound into the design instance.
`timescale 1ns/10ps
module return_stack_call_reset_ops_test;
  reg mclk = 1'h0;
  reg rst_n = 1'h0;
  reg vld = 1'h0;
  reg [15:0] wd = 16'h0000;
  reg [4:0] sti = 5'h15;
  wire [20:0] pc, top;
  wire [4:0] st, sp;
  wire mcr, busy;
  wire [1:0] q;
  reg [20:0] p;
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 mclk = ~mclk;
  rsx_exec i_rsx_exec (.mclk(mclk), .rst_n(rst_n), .instr_valid(vld),
    .instr_word(wd), .status_in(sti), .pc_out(pc), .status_out(st),
    .stack_top_value(top), .stack_ptr(sp), .master_clear_reset(mcr),
    .busy(busy), .q_phase(q));
  task chk(input [20:0] s, input [20:0] e);
    begin
      checks_done++;
      if (s !== e)
      begin
        mismatches++;
        $display("Error at %0t: %h vs %h", $time, s, e);
      end
    end
  endtask
  // Waits for an open slot, so refused words are never offered.
  task issue(input [15:0] w);
    begin
      while (q !== 2'h0 || busy !== 1'h0 || mcr !== 1'h0)
        @(negedge mclk);
      p = pc;
      wd = w;
      vld = 1'h1;
      @(negedge mclk);
      vld = 1'h0;
    end
  endtask
  task t_stack;
    reg [20:0] a;
    begin
      issue(16'h0005);
      a = p + 21'h2;
      chk(top, a);
      issue(16'h0005);
      chk(sp, 21'h2);
      sti = 5'h0a;
      issue(16'h0006);
      chk(top, a);
      chk(sp, 21'h1);
      chk(st, 5'h0a);
      chk(pc, p + 21'h2);
    end
  endtask
  task t_call(input [10:0] n);
    reg [20:0] t;
    reg [4:0] s;
    begin
      issue({5'h1b, n});
      t = p + 21'h2 + {{9{n[10]}}, n, 1'h0};
      s = sp;
      chk(pc, t);
      chk(top, p + 21'h2);
      chk(busy, 21'h1);
      repeat (3) @(negedge mclk);
      wd = 16'h0005;
      vld = 1'h1;
      @(negedge mclk);
      vld = 1'h0;
      chk(busy, 21'h1);
      chk(sp, s);
      chk(pc, t);
    end
  endtask
  task t_reset;
    begin
      issue(16'h00ff);
      chk(mcr, 21'h1);
      @(negedge mclk);
      chk(pc + sp + st, 21'h0);
      chk(mcr, 21'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    rst_n = 1'h1;
    t_stack;
    t_call(11'h400);
    t_call(11'h3ff);
    t_reset;
    end_of_test;
  end
  initial
  begin
    #10000;
    mismatches++;
    end_of_test;
  end
endmodule
